// ===== hw/bmc_mode_control.sv
/*
 Mode control of a battery pack monitor: power modes, presence,
 bus-off and idle detection, offset calibration start, coulomb counter,
 temperature range, charge report, FET and fuse drive.
 Assumes pins arrive asynchronously and ADC results on clk.
*/
`timescale 1ns/1ps
module bmc_mode_control #(
   parameter int unsigned PASS_CYCLES  = bmc_pkg::PASS_CYC,
   parameter int unsigned OFF_CYCLES   = bmc_pkg::OFF_CYC,
   parameter int unsigned AVAIL_CYCLES = bmc_pkg::AVAIL_CYC,
   parameter int unsigned IDLE_CYCLES  = bmc_pkg::IDLE_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [31:0]               reg_rdata,
   input  wire logic                 pack_present_input,
   input  wire logic                 bus_clock_pin,
   input  wire logic                 bus_data_pin,
   input  wire logic [15:0]          sense_positive_input,
   input  wire logic [15:0]          sense_negative_input,
   input  wire logic                 sense_valid,
   input  wire logic [15:0]          temp_internal,
   input  wire logic [15:0]          thermistor_input_one,
   input  wire logic [15:0]          thermistor_input_two,
   input  wire logic                 fault_detected,
   input  wire logic                 secondary_fault,
   output logic                      charge_fet,
   output logic                      discharge_fet,
   output logic                      zero_volt_charge_fet,
   output logic                      fuse_blow,
   output logic                      pass_pulse,
   output logic                      offset_cal_start,
   output logic                      bus_enable,
   output logic                      bus_abort,
   output logic                      broadcast_start,
   output bmc_pkg::bmc_chg_type      charge_report
);

   logic [7:0]             ctrl_reg;
   logic [31:0]            pack_present_input_period_reg;
   logic [31:0]            sleep_int_reg;
   logic [15:0]            wake_thr_reg;
   logic [31:0]            cal_low_reg;
   logic [2:0][2:0]        sync_reg;
   logic [2:0]             level_reg;
   logic                   pack_present_input_level;
   logic                   scl_level;
   logic                   sda_level;
   logic [31:0]            pack_present_input_cnt_reg;
   logic                   pack_present_input_high_reg;
   logic                   removed;
   bmc_pkg::bmc_mode_type  mode_reg;
   bmc_pkg::bmc_mode_type  mode_next;
   logic                   sleep_cmd;
   logic                   shut_cmd;
   logic                   active;
   logic signed [16:0]     sense_diff;
   logic [16:0]            sense_mag;
   logic                   wake_cond;
   logic [31:0]            pass_cnt_reg;
   logic [31:0]            pass_limit;
   logic signed [31:0]     count_reg;
   logic [15:0]            temp_sel;
   bmc_pkg::bmc_trange_type trange_reg;
   logic                   fuse_reg;
   logic                   both_low;
   logic                   both_high;
   logic [31:0]            low_cnt_reg;
   logic [31:0]            high_cnt_reg;
   logic                   bus_off_reg;
   logic [31:0]            avail_cnt_reg;
   logic                   avail_reg;
   logic                   cal_busy_reg;

   // strobes can collide in one write; shutdown takes priority over sleep
   assign sleep_cmd = reg_wr && reg_addr == bmc_pkg::ADDR_CTRL
                      && reg_wdata[bmc_pkg::CTRL_SLEEP];
   assign shut_cmd  = reg_wr && reg_addr == bmc_pkg::ADDR_CTRL
                      && reg_wdata[bmc_pkg::CTRL_SHUT];

   // reset values stand in for nonvolatile copy
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg        <= bmc_pkg::CTRL_RST; // R20
         pack_present_input_period_reg <= bmc_pkg::PACK_PRESENT_INPUT_RST;
         sleep_int_reg   <= bmc_pkg::SLEEP_RST;
         wake_thr_reg    <= bmc_pkg::WAKE_RST;
         cal_low_reg     <= bmc_pkg::CAL_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            bmc_pkg::ADDR_CTRL: begin
               // sleep and shutdown bits act as commands, not stored
               ctrl_reg <= {reg_wdata[7:5], 2'h0, reg_wdata[2:0]};
            end
            bmc_pkg::ADDR_PACK_PRESENT_INPUT:  pack_present_input_period_reg <= reg_wdata;
            bmc_pkg::ADDR_SLEEP: sleep_int_reg   <= reg_wdata;
            bmc_pkg::ADDR_WAKE:  wake_thr_reg    <= reg_wdata[15:0];
            bmc_pkg::ADDR_CAL:   cal_low_reg     <= reg_wdata;
            default: ;
         endcase
      end
   end

   // pins: three flops, a change counts once the last two agree
   generate
      for (genvar i = 0; i < 3; i++) begin : g_sync
         logic pin;
         assign pin = (i == 0) ? pack_present_input
                    : (i == 1) ? bus_clock_pin : bus_data_pin;
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               sync_reg[i]  <= 3'h7;
               level_reg[i] <= 1'b1;
            end else begin
               sync_reg[i] <= {sync_reg[i][1:0], pin};
               if (sync_reg[i][1] == sync_reg[i][2]) begin
                  level_reg[i] <= sync_reg[i][2];
               end
            end
         end
      end
   endgenerate

   assign pack_present_input_level = level_reg[0];
   assign scl_level  = level_reg[1];
   assign sda_level  = level_reg[2];

   // presence is looked at only once per sampling period
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pack_present_input_cnt_reg  <= 32'h0000_0000;
         pack_present_input_high_reg <= 1'b0;
      end else if (pack_present_input_cnt_reg + 32'h1 >= pack_present_input_period_reg) begin
         pack_present_input_cnt_reg  <= 32'h0000_0000;
         pack_present_input_high_reg <= pack_present_input_level; // R5
      end else begin
         pack_present_input_cnt_reg <= pack_present_input_cnt_reg + 32'h1;
      end
   end

   assign removed = pack_present_input_high_reg && !ctrl_reg[bmc_pkg::CTRL_NONREM]; // R7

   // wake on the magnitude of the sensed current
   assign sense_diff = $signed({sense_positive_input[15], sense_positive_input})
                     - $signed({sense_negative_input[15], sense_negative_input});
   assign sense_mag  = sense_diff[16] ? 17'(-sense_diff) : 17'(sense_diff);
   assign wake_cond  = ctrl_reg[bmc_pkg::CTRL_WAKE_EN] && sense_valid
                       && sense_mag >= {1'b0, wake_thr_reg}; // R4

   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         bmc_pkg::MODE_NORMAL: begin
            if (shut_cmd) begin
               mode_next = bmc_pkg::MODE_SHUTDOWN;
            end else if (removed) begin
               mode_next = bmc_pkg::MODE_REMOVED; // R6
            end else if (sleep_cmd && !wake_cond && !fault_detected) begin
               mode_next = bmc_pkg::MODE_SLEEP;
            end
         end
         bmc_pkg::MODE_SLEEP: begin
            if (shut_cmd) begin
               mode_next = bmc_pkg::MODE_SHUTDOWN;
            end else if (removed) begin
               mode_next = bmc_pkg::MODE_REMOVED; // R6
            end else if (wake_cond || fault_detected) begin
               mode_next = bmc_pkg::MODE_NORMAL; // R2
            end
         end
         bmc_pkg::MODE_REMOVED: begin
            if (shut_cmd) begin
               mode_next = bmc_pkg::MODE_SHUTDOWN;
            end else if (!removed) begin
               mode_next = bmc_pkg::MODE_NORMAL; // R5
            end
         end
         // only a reset leaves shutdown
         bmc_pkg::MODE_SHUTDOWN: mode_next = bmc_pkg::MODE_SHUTDOWN; // R3
         default: mode_next = bmc_pkg::MODE_NORMAL;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg <= bmc_pkg::MODE_NORMAL;
      end else begin
         mode_reg <= mode_next;
      end
   end

   assign active = mode_reg == bmc_pkg::MODE_NORMAL
                || mode_reg == bmc_pkg::MODE_SLEEP;

   // timer restarts on any mode change
   assign pass_limit = (mode_reg == bmc_pkg::MODE_SLEEP)
                     ? sleep_int_reg : 32'(PASS_CYCLES); // R1 R2

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pass_cnt_reg <= 32'h0000_0000;
         pass_pulse   <= 1'b0;
      end else if (!active || mode_next != mode_reg) begin
         pass_cnt_reg <= 32'h0000_0000; // R3
         pass_pulse   <= 1'b0;
      end else if (pass_cnt_reg + 32'h1 >= pass_limit) begin
         pass_cnt_reg <= 32'h0000_0000;
         pass_pulse   <= 1'b1; // R1 R2 R12
      end else begin
         pass_cnt_reg <= pass_cnt_reg + 32'h1;
         pass_pulse   <= 1'b0;
      end
   end

   // one count is 0.65 nVh; positive is charge, negative discharge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= 32'sh0000_0000;
      end else if (sense_valid && mode_reg != bmc_pkg::MODE_SHUTDOWN) begin
         count_reg <= count_reg + 32'(sense_diff); // R11
      end
   end

   // both thermistors: the hotter one governs
   always_comb begin
      case (ctrl_reg[bmc_pkg::CTRL_TSEL +: 2])
         bmc_pkg::TSEL_INT: temp_sel = temp_internal; // R13
         bmc_pkg::TSEL_ONE: temp_sel = thermistor_input_one;
         bmc_pkg::TSEL_TWO: temp_sel = thermistor_input_two;
         bmc_pkg::TSEL_BOTH: begin
            temp_sel = (thermistor_input_one > thermistor_input_two)
                     ? thermistor_input_one : thermistor_input_two;
         end
         default: temp_sel = temp_internal;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trange_reg <= bmc_pkg::TR_OUT;
      end else if (temp_sel < bmc_pkg::T_MIN || temp_sel >= bmc_pkg::T_MAX) begin
         trange_reg <= bmc_pkg::TR_OUT; // R17
      end else if (temp_sel < bmc_pkg::T_MID) begin
         trange_reg <= bmc_pkg::TR_COLD;
      end else if (temp_sel < bmc_pkg::T_HOT) begin
         trange_reg <= bmc_pkg::TR_STD;
      end else begin
         trange_reg <= bmc_pkg::TR_HOT;
      end
   end

   // at each pass, report zero while out of temperature range
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         charge_report <= '0;
      end else if (pass_pulse) begin
         case (trange_reg)
            bmc_pkg::TR_COLD: charge_report <= {bmc_pkg::V_COLD, bmc_pkg::I_COLD}; // R15
            bmc_pkg::TR_STD:  charge_report <= {bmc_pkg::V_STD, bmc_pkg::I_STD};
            bmc_pkg::TR_HOT:  charge_report <= {bmc_pkg::V_HOT, bmc_pkg::I_HOT};
            default:          charge_report <= '0; // R17
         endcase
      end
   end

   // sticky: once blown only a reset clears it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fuse_reg <= 1'b0;
      end else if (secondary_fault && mode_reg != bmc_pkg::MODE_SHUTDOWN) begin
         fuse_reg <= 1'b1; // R14
      end
   end

   assign fuse_blow = fuse_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         charge_fet           <= 1'b0;
         discharge_fet        <= 1'b0;
         zero_volt_charge_fet <= 1'b0;
      end else begin
         discharge_fet        <= active && !fuse_reg; // R6
         charge_fet           <= active && !fuse_reg
                                 && trange_reg != bmc_pkg::TR_OUT; // R17
         zero_volt_charge_fet <= active && !fuse_reg
                                 && trange_reg != bmc_pkg::TR_OUT; // R6
      end
   end

   assign both_low  = !scl_level && !sda_level;
   assign both_high = scl_level && sda_level;

   // low time counter saturates so long holds never wrap
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt_reg <= 32'h0000_0000;
      end else if (!both_low) begin
         low_cnt_reg <= 32'h0000_0000;
      end else if (low_cnt_reg != 32'hFFFF_FFFF) begin
         low_cnt_reg <= low_cnt_reg + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         high_cnt_reg <= 32'h0000_0000;
      end else if (!both_high) begin
         high_cnt_reg <= 32'h0000_0000;
      end else if (high_cnt_reg != 32'hFFFF_FFFF) begin
         high_cnt_reg <= high_cnt_reg + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_off_reg <= 1'b0;
      end else if (!both_low) begin
         bus_off_reg <= 1'b0; // R9
      end else if (low_cnt_reg + 32'h1 >= 32'(OFF_CYCLES)) begin
         bus_off_reg <= 1'b1; // R8
      end
   end

   // after bus-off the interface returns a fixed delay later
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avail_cnt_reg <= 32'h0000_0000;
         avail_reg     <= 1'b1;
      end else if (bus_off_reg) begin
         avail_cnt_reg <= 32'h0000_0000;
         avail_reg     <= 1'b0; // R21
      end else if (!avail_reg) begin
         if (avail_cnt_reg + 32'h1 >= 32'(AVAIL_CYCLES)) begin
            avail_reg <= 1'b1; // R9
         end else begin
            avail_cnt_reg <= avail_cnt_reg + 32'h1;
         end
      end
   end

   // one calibration start per low episode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         offset_cal_start <= 1'b0;
         cal_busy_reg     <= 1'b0;
      end else begin
         offset_cal_start <= 1'b0;
         if (!both_low) begin
            cal_busy_reg <= 1'b0;
         end else if (low_cnt_reg + 32'h1 == cal_low_reg
                      && mode_reg != bmc_pkg::MODE_SHUTDOWN) begin
            offset_cal_start <= 1'b1; // R10
            cal_busy_reg     <= 1'b1;
         end
      end
   end

   // idle abort pulses once per long-high stretch
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_abort <= 1'b0;
      end else begin
         bus_abort <= both_high && high_cnt_reg + 32'h1 == 32'(IDLE_CYCLES)
                      && !ctrl_reg[bmc_pkg::CTRL_NO_STR]; // R19
      end
   end

   // the serial engine outside speaks the protocol, gated from here
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_enable      <= 1'b0;
         broadcast_start <= 1'b0;
      end else begin
         bus_enable      <= avail_reg && !bus_off_reg
                            && mode_reg != bmc_pkg::MODE_SHUTDOWN; // R18 R21
         broadcast_start <= pass_pulse && bus_enable
                            && mode_reg == bmc_pkg::MODE_NORMAL; // R16 R21
      end
   end

   // read data in the cycle after the strobe only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (!reg_rd) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         case (reg_addr)
            bmc_pkg::ADDR_CTRL:  reg_rdata <= {24'h000000, ctrl_reg};
            bmc_pkg::ADDR_PACK_PRESENT_INPUT:  reg_rdata <= pack_present_input_period_reg;
            bmc_pkg::ADDR_SLEEP: reg_rdata <= sleep_int_reg;
            bmc_pkg::ADDR_WAKE:  reg_rdata <= {16'h0000, wake_thr_reg};
            bmc_pkg::ADDR_CAL:   reg_rdata <= cal_low_reg;
            bmc_pkg::ADDR_STATUS: begin
               reg_rdata <= {22'h000000, trange_reg, cal_busy_reg,
                             fuse_reg, avail_reg, bus_off_reg,
                             pack_present_input_high_reg, removed, mode_reg};
            end
            bmc_pkg::ADDR_COUNT: reg_rdata <= count_reg;
            bmc_pkg::ADDR_CHG:   reg_rdata <= charge_report;
            default:             reg_rdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule // bmc_mode_control

// ===== pkg/bmc_pkg.sv
/*
 Constants, types and register map of the battery monitor mode control.
 Assumes a 40 MHz clock and a plain register port on the same clock.
*/
// Function
// R1: normal mode runs one pass each second.
// R2: sleep runs passes at set interval; current or fault wakes.
// R3: shutdown stops all activity; bus_abort still pulses on a long idle in shutdown.
// R4: enabled wake: current at threshold leaves sleep.
// R5: presence sampled periodically; low enters normal.
// R6: presence high: removed, all FETs off.
// R7: non-removable option ignores presence.
// R8: both lines low 2 s: bus-off.
// R9: a line high clears bus-off; bus back within 1 ms.
// R10: both lines low for set time start offset calibration.
// R11: sense flow accumulated signed; positive is charge.
// R12: cell voltages refreshed once per second.
// R13: temperature from internal sensor or two thermistors.
// R14: secondary fault asserts fuse-blow output.
// R15: charge report follows temperature range.
// R16: charge values broadcast to charger.
// R17: no charging out of temperature range.
// R18: both sides use bus revision 1.1 with error checking.
// R19: both lines high over 50 ms aborts, unless no-stretch.
// R20: timing and wake settings are configuration.
// R21: bus-off blocks bus traffic until available again.
package bmc_pkg;

   localparam int unsigned CLK_HZ   = 40_000_000;
   localparam int unsigned PASS_MS  = 1000;
   localparam int unsigned OFF_MS   = 2000;
   localparam int unsigned AVAIL_US = 1000;
   localparam int unsigned IDLE_MS  = 50;
   localparam int unsigned PASS_CYC  = CLK_HZ / 1000 * PASS_MS;
   localparam int unsigned OFF_CYC   = CLK_HZ / 1000 * OFF_MS;
   localparam int unsigned AVAIL_CYC = CLK_HZ / 1_000_000 * AVAIL_US;
   localparam int unsigned IDLE_CYC  = CLK_HZ / 1000 * IDLE_MS;

   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_PACK_PRESENT_INPUT   = 8'h04;
   localparam logic [7:0] ADDR_SLEEP  = 8'h08;
   localparam logic [7:0] ADDR_WAKE   = 8'h0C;
   localparam logic [7:0] ADDR_CAL    = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_COUNT  = 8'h18;
   localparam logic [7:0] ADDR_CHG    = 8'h1C;

   localparam int CTRL_NONREM  = 0;
   localparam int CTRL_WAKE_EN = 1;
   localparam int CTRL_NO_STR  = 2;
   localparam int CTRL_SLEEP   = 3;
   localparam int CTRL_SHUT    = 4;
   localparam int CTRL_TSEL    = 5;

   localparam logic [7:0]  CTRL_RST  = 8'h02;
   localparam logic [31:0] PACK_PRESENT_INPUT_RST  = 32'h0000_9C40;
   localparam logic [31:0] SLEEP_RST = 32'h04C4_B400;
   localparam logic [15:0] WAKE_RST  = 16'h0040;
   localparam logic [31:0] CAL_RST   = 32'h0013_12D0;

   localparam logic [1:0] TSEL_INT  = 2'h0;
   localparam logic [1:0] TSEL_ONE  = 2'h1;
   localparam logic [1:0] TSEL_TWO  = 2'h2;
   localparam logic [1:0] TSEL_BOTH = 2'h3;

   // temperatures in 0.1 K
   localparam logic [15:0] T_MIN = 16'h0AAB;
   localparam logic [15:0] T_MID = 16'h0B0F;
   localparam logic [15:0] T_HOT = 16'h0C6D;
   localparam logic [15:0] T_MAX = 16'h0CD1;

   localparam logic [15:0] V_COLD = 16'h3840;
   localparam logic [15:0] I_COLD = 16'h03E8;
   localparam logic [15:0] V_STD  = 16'h3840;
   localparam logic [15:0] I_STD  = 16'h0FA0;
   localparam logic [15:0] V_HOT  = 16'h3700;
   localparam logic [15:0] I_HOT  = 16'h07D0;

   typedef enum logic [1:0] {
      TR_COLD, TR_STD, TR_HOT, TR_OUT
   } bmc_trange_type;

   typedef enum logic [1:0] {
      MODE_NORMAL, MODE_SLEEP, MODE_SHUTDOWN, MODE_REMOVED
   } bmc_mode_type;

   typedef struct packed {
      logic [15:0] voltage;
      logic [15:0] current;
   } bmc_chg_type;

endpackage

// ===== sim/bmc_bus_host.sv
/* far-side bus host: drives both bus lines, link clock 200 ns.
 assumes pull-ups, so a released line reads high */
`timescale 1ns/1ps
module bmc_bus_host (
   input wire logic [1:0] req,
   output logic           bus_clock_pin = 1'b1,
   output logic           bus_data_pin = 1'b1
);
   // clock runs only inside a frame; data moves while clock low
   always begin
      #100;
      case (req)
         2'h1: {bus_clock_pin, bus_data_pin} = 2'b00;
         2'h2: begin
            bus_clock_pin = ~bus_clock_pin;
            bus_data_pin = bus_clock_pin ? bus_data_pin : ~bus_data_pin;
         end
         default: {bus_clock_pin, bus_data_pin} = 2'b11;
      endcase
   end
endmodule // bmc_bus_host

// ===== sim/bmc_mode_control_bench.sv
/* bench of bmc_mode_control with a bus host.
 assumes short counts at the instance */
`timescale 1ns/1ps
module bmc_mode_control_bench;
   logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata, acc = '0, v;
   logic pack_present_input = 1'b0, sense_valid = 1'b0, fault_detected = 1'b0;
   logic secondary_fault = 1'b0, bus_clock_pin, bus_data_pin;
   logic [15:0] sense_positive_input = '0, sense_negative_input = '0;
   logic [15:0] temp_internal = 16'h0BB8, thermistor_input_one = 16'h0BB8;
   logic [15:0] thermistor_input_two = 16'h0BB8;
   logic charge_fet, discharge_fet, zero_volt_charge_fet, fuse_blow, pass_pulse;
   logic offset_cal_start, bus_enable, bus_abort, broadcast_start;
   logic [1:0] req = 2'h0;
   bmc_pkg::bmc_chg_type charge_report;
   logic [31:0] expq[$];
   logic [15:0] tt[3] = '{16'h0AAC, 16'h0BB8, 16'h0C6E};
   logic [31:0] rr[3] = '{{bmc_pkg::V_COLD, bmc_pkg::I_COLD},
      {bmc_pkg::V_STD, bmc_pkg::I_STD}, {bmc_pkg::V_HOT, bmc_pkg::I_HOT}};
   int num_errors = 0, checks_done = 0, cyc = 0, n, aborts, passes, seed = 48269;
   bmc_mode_control #(.PASS_CYCLES(100), .OFF_CYCLES(200), .AVAIL_CYCLES(20),
      .IDLE_CYCLES(50)) u_dut (.*);
   bmc_bus_host u_host (.*);
   always #12.5 clk = ~clk;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   // n counts edges waited
   task automatic hunt(ref logic s, input logic lv, input int lim);
      n = 0;
      while (s !== lv && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   always @(posedge clk) begin
      if (pass_pulse === 1'b1)
         passes++;
      if (bus_abort === 1'b1)
         aborts++;
      if (rd_d)
         chk(reg_rdata, expq.pop_front());
      rd_d <= reg_rd;
      if (++cyc == 12000) begin
         num_errors++;
         wrap_up();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'h00, 32'h02);
      rd(8'h04, 32'h9C40);
      rd(8'h08, 32'h04C4B400);
      rd(8'h10, 32'h001312D0);
      rd(8'h20, 32'h0);
      rd(8'h14, 32'h120);
      v = $random(seed);
      wr(8'h0C, v);
      rd(8'h0C, {16'h0, v[15:0]});
      wr(8'h18, v);
      rd(8'h18, 32'h0);
      wr(8'h04, 32'h8);
      $display("registers done");
      hunt(pass_pulse, 1'b1, 120);
      @(posedge clk);
      hunt(pass_pulse, 1'b1, 120);
      chk(n + 1, 100);
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         @(posedge clk);
         {sense_positive_input, sense_negative_input, sense_valid} <=
            {8'h00, v[7:0], 8'h00, v[15:8], 1'b1};
         acc = acc + v[7:0] - v[15:8];
         @(posedge clk);
         sense_valid <= 1'b0;
      end
      rd(8'h18, acc);
      temp_internal <= 16'h0CD2;
      repeat (4) @(posedge clk);
      chk({charge_fet, zero_volt_charge_fet, discharge_fet}, 3'b001);
      rd(8'h14, 32'h320);
      wr(8'h00, 32'h22);
      for (int i = 0; i < 3; i++) begin
         thermistor_input_one <= tt[i];
         repeat (2) @(posedge clk);
         hunt(pass_pulse, 1'b1, 120);
         repeat (3) @(posedge clk);
         chk(charge_report, rr[i]);
      end
      chk(charge_fet, 1'b1);
      wr(8'h00, 32'h02);
      temp_internal <= 16'h0BB8;
      $display("passes and ranges done");
      pack_present_input <= 1'b1;
      repeat (20) @(posedge clk);
      chk({charge_fet, discharge_fet, zero_volt_charge_fet}, 3'b000);
      rd(8'h14, 32'h12F);
      pack_present_input <= 1'b0;
      repeat (20) @(posedge clk);
      chk(charge_fet, 1'b1);
      wr(8'h00, 32'h03);
      pack_present_input <= 1'b1;
      repeat (20) @(posedge clk);
      chk(discharge_fet, 1'b1);
      pack_present_input <= 1'b0;
      repeat (12) @(posedge clk);
      wr(8'h08, 32'd40);
      wr(8'h0C, 32'h40);
      wr(8'h00, 32'h0B);
      rd(8'h14, 32'h121);
      hunt(pass_pulse, 1'b1, 60);
      @(posedge clk);
      hunt(pass_pulse, 1'b1, 60);
      chk(n + 1, 40);
      {sense_positive_input, sense_negative_input, sense_valid} <= {16'h40, 16'h0, 1'b1};
      @(posedge clk);
      sense_valid <= 1'b0;
      rd(8'h14, 32'h120);
      wr(8'h00, 32'h0B);
      fault_detected <= 1'b1;
      @(posedge clk);
      fault_detected <= 1'b0;
      rd(8'h14, 32'h120);
      $display("presence and sleep done");
      wr(8'h10, 32'd30);
      req <= 2'h1;
      hunt(offset_cal_start, 1'b1, 60);
      chk(offset_cal_start, 1'b1);
      hunt(bus_enable, 1'b0, 260);
      chk(n > 150, 1'b1);
      req <= 2'h2;
      hunt(bus_enable, 1'b1, 60);
      chk(n < 36, 1'b1);
      aborts = 0;
      repeat (80) @(posedge clk);
      chk(aborts, 0);
      req <= 2'h0;
      repeat (70) @(posedge clk);
      chk(aborts, 1);
      wr(8'h00, 32'h07);
      req <= 2'h2;
      repeat (20) @(posedge clk);
      req <= 2'h0;
      repeat (70) @(posedge clk);
      chk(aborts, 1);
      secondary_fault <= 1'b1;
      @(posedge clk);
      secondary_fault <= 1'b0;
      repeat (4) @(posedge clk);
      chk({fuse_blow, charge_fet, discharge_fet}, 3'b100);
      wr(8'h00, 32'h13);
      passes = 0;
      repeat (300) @(posedge clk);
      chk({passes[30:0], bus_enable}, 32'h0);
      reset_n <= 1'b0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'h00, 32'h02);
      repeat (3) @(posedge clk);
      chk(fuse_blow, 1'b0);
      $display("bus, fuse and shutdown done");
      wrap_up();
   end
endmodule // bmc_mode_control_bench

// ===== sim/bmc_mode_control_chk.sv
/* checker of bmc_mode_control ports.
 assumes short counts passed by the bind */
`timescale 1ns/1ps
module bmc_chk #(parameter int unsigned OFF_CYCLES = 200) (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        bus_clock_pin,
   input wire logic        bus_data_pin,
   input wire logic        secondary_fault,
   input wire logic        charge_fet,
   input wire logic        discharge_fet,
   input wire logic        zero_volt_charge_fet,
   input wire logic        fuse_blow,
   input wire logic        pass_pulse,
   input wire logic        offset_cal_start,
   input wire logic        bus_enable,
   input wire logic        bus_abort,
   input wire logic        broadcast_start
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [31:0] low_reg;
   // raw pin count; sync lag needs margin
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         low_reg <= '0;
      else
         low_reg <= (bus_clock_pin | bus_data_pin) ? '0 : low_reg + 1;
   a_fuse_sticky: assert property (fuse_blow |=> fuse_blow)
      else $error("fuse output dropped");
   a_fuse_fets: assert property ($past(fuse_blow) |->
      !(charge_fet | discharge_fet | zero_volt_charge_fet)) else $error("fet on with fuse");
   a_fault_fuse: assert property (secondary_fault |-> ##[1:4] fuse_blow)
      else $error("fuse not set");
   a_pass_gap: assert property (pass_pulse |=> !pass_pulse [*8])
      else $error("passes too close");
   a_bcast_pass: assert property (broadcast_start |-> $past(pass_pulse))
      else $error("broadcast without pass");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside slot");
   a_cal_single: assert property (offset_cal_start |-> low_reg > 2 ##1 !offset_cal_start)
      else $error("bad calibration start");
   a_busoff_gate: assert property (low_reg > OFF_CYCLES + 8 |-> !bus_enable)
      else $error("bus enabled while off");
   a_abort_idle: assert property (bus_abort |-> $past(bus_clock_pin, 4)
      && $past(bus_data_pin, 4)) else $error("abort with line low");
endmodule // bmc_chk
bind bmc_mode_control bmc_chk #(.OFF_CYCLES(OFF_CYCLES)) u_chk (.*);
